// ### core/res_seq.sv
`timescale 1ns/1ps
`default_nettype none
module res_seq import res_pkg::*; #(
  parameter int NIRQ = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk_pin,
  input wire logic supply_droop_pin,
  input wire logic monitor_entry_reset_pin,
  input wire logic ext_reset_pin_i,
  output logic ext_reset_o,
  output logic ext_reset_oe,
  input wire res_core_t core,
  input wire logic [NIRQ-1:0] irq_req,
  input wire logic wake_i,
  output logic core_reset_n,
  output logic bus_clk_en,
  output logic wdog_tick,
  output logic int_take,
  output logic [15:0] vector_addr,
  output logic stack_pc_minus1,
  output logic set_imask,
  output logic push_index_high
);
  // synchroniser stages for asynchronous pins
  logic [SY_N-1:0] sync_s1_ff;
  logic [SY_N-1:0] sync_s2_ff;
  logic osc_prev_ff; // delayed oscillator level for edge detect
  res_state_t state_ff, nxt_state;
  logic [11:0] pre_ff; // prescale counter
  logic [5:0] phase_ff, nxt_phase; // drive/hold tick counter
  logic short_rec_ff; // short recovery sampled at wake
  res_cause_t cause_ff;
  logic [1:0] ctrl_ff; // stop enable, short recovery
  logic [NIRQ-1:0] irq_en_ff;
  logic latched_ff;
  logic imask_q_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic ext_oe_ff, core_rst_n_ff, bus_en_ff, wdog_ff;
  logic take_ff, pcm1_ff, imask_set_ff;
  logic [15:0] vec_ff;

  // two flops per pin; only the second stage is read
  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // pin lane starts at its idle high so reset is no pin reset
          sync_s1_ff[gi] <= 1'(gi == SY_PIN);
          sync_s2_ff[gi] <= 1'(gi == SY_PIN);
        end else if (ce) begin
          sync_s1_ff[gi] <= (gi == SY_PIN) ? ext_reset_pin_i :
                            (gi == SY_DROOP) ? supply_droop_pin :
                            (gi == SY_MON) ? monitor_entry_reset_pin :
                            osc_clk_pin;
          sync_s2_ff[gi] <= sync_s1_ff[gi];
        end
      end
    end
  endgenerate

  // falling oscillator edge becomes a one-cycle tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_ff <= 1'b0;
    end else if (ce) begin
      osc_prev_ff <= sync_s2_ff[SY_OSC];
    end
  end
  logic osc_tick;
  assign osc_tick = osc_prev_ff & ~sync_s2_ff[SY_OSC];

  // event decode; internal sources only count while running, droop in any state but RS_STAB, pin in RS_RUN, RS_STOP, RS_RECOV and RS_EXT
  logic in_run, bad_op_evt, bad_addr_evt, mon_evt, droop_evt;
  logic pin_low, int_src;
  logic stop_ok, pre_ovf, rec_done;
  assign in_run = (state_ff == RS_RUN);
  // stop with stop disabled is an illegal opcode
  assign bad_op_evt = in_run & ((core.opcode_valid & core.opcode_illegal) |
                      (core.stop_exec & ~ctrl_ff[CTRL_STOPEN_BIT]));
  // only an opcode fetch qualifies; data reads are ignored
  assign bad_addr_evt = in_run & core.fetch_unmapped &
                        core.opcode_fetch;
  assign mon_evt = in_run & sync_s2_ff[SY_MON];
  // droop restarts the long sequence unless already in it
  assign droop_evt = sync_s2_ff[SY_DROOP] & (state_ff != RS_STAB);
  assign pin_low = ~sync_s2_ff[SY_PIN];
  assign int_src = bad_op_evt | bad_addr_evt | mon_evt;
  assign stop_ok = in_run & core.stop_exec & ctrl_ff[CTRL_STOPEN_BIT];
  assign pre_ovf = osc_tick & (pre_ff == PRE_MAX);
  // recovery length chosen by the value sampled at wake
  assign rec_done = osc_tick &
                    (pre_ff == (short_rec_ff ? PRE_SHORT_LAST : PRE_MAX));

  // reset and stop sequencer; droop outranks everything
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RS_RUN: begin
        if (int_src) nxt_state = RS_DRIVE;
        else if (pin_low) nxt_state = RS_EXT;
        else if (stop_ok) nxt_state = RS_STOP;
      end
      RS_STAB: begin
        // oscillator settles for one full prescaler lap
        if (pre_ovf) nxt_state = RS_DRIVE;
      end
      RS_DRIVE: begin
        if (osc_tick && phase_ff == PHASE_LAST) nxt_state = RS_HOLD;
      end
      RS_HOLD: begin
        if (osc_tick && phase_ff == PHASE_LAST) nxt_state = RS_RUN;
      end
      RS_STOP: begin
        if (pin_low) nxt_state = RS_EXT;
        else if (wake_i) nxt_state = RS_RECOV;
      end
      RS_RECOV: begin
        if (pin_low) nxt_state = RS_EXT;
        else if (rec_done) nxt_state = RS_RUN;
      end
      RS_EXT: begin
        // the pin itself halts processing while low
        if (!pin_low) nxt_state = RS_RUN;
      end
      default: nxt_state = RS_STAB;
    endcase
    if (droop_evt) nxt_state = RS_STAB;
  end

  // phase count restarts whenever the state changes
  always_comb begin
    nxt_phase = phase_ff;
    if (nxt_state != state_ff) nxt_phase = 6'h00;
    else if (osc_tick) nxt_phase = 6'(phase_ff + 6'h01);
  end

  // state, phase and sampled recovery option
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RS_STAB;
      phase_ff <= 6'h00;
      short_rec_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      if (state_ff == RS_STOP && wake_i) begin
        short_rec_ff <= ctrl_ff[CTRL_SHORT_BIT];
      end
    end
  end

  // prescaler: internal resets and stop clear it, pin reset does not
  logic pre_clr;
  assign pre_clr = (nxt_state != state_ff) &
                   (nxt_state == RS_STAB || nxt_state == RS_DRIVE ||
                    nxt_state == RS_STOP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 12'h000;
      wdog_ff <= 1'b0;
    end else if (ce) begin
      // every overflow outside stop ticks the watchdog
      wdog_ff <= pre_ovf & (state_ff != RS_STOP);
      if (pre_clr) pre_ff <= 12'h000;
      else if (state_ff == RS_STOP) pre_ff <= 12'h000;
      else if (osc_tick) pre_ff <= 12'(pre_ff + 12'h001);
    end
  end

  // cause register keeps only the latest reset source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= '{por: 1'b1, default: 1'b0};
    end else if (ce && nxt_state != state_ff) begin
      if (nxt_state == RS_STAB) begin
        cause_ff <= '{droop: 1'b1, default: 1'b0};
      end else if (nxt_state == RS_EXT) begin
        cause_ff <= '{pin: 1'b1, default: 1'b0};
      end else if (nxt_state == RS_DRIVE && state_ff == RS_RUN) begin
        // one source wins when several arrive together
        if (mon_evt) cause_ff <= '{mon_entry: 1'b1, default: 1'b0};
        else if (bad_addr_evt) begin
          cause_ff <= '{bad_addr: 1'b1, default: 1'b0};
        end else cause_ff <= '{bad_op: 1'b1, default: 1'b0};
      end
    end
  end

  // pin and clock outputs follow the next state, so stay registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_oe_ff <= 1'b1;
      core_rst_n_ff <= 1'b0;
      bus_en_ff <= 1'b0;
    end else if (ce) begin
      ext_oe_ff <= (nxt_state == RS_STAB || nxt_state == RS_DRIVE);
      core_rst_n_ff <= ~(nxt_state == RS_STAB || nxt_state == RS_DRIVE ||
                         nxt_state == RS_HOLD || nxt_state == RS_EXT);
      bus_en_ff <= ~(nxt_state == RS_STAB || nxt_state == RS_STOP ||
                     nxt_state == RS_RECOV);
    end
  end

  // priority pick: lowest index is highest priority
  logic [NIRQ-1:0] active;
  logic [2:0] pick;
  assign active = irq_req & irq_en_ff;
  always_comb begin
    pick = 3'h0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (active[i]) pick = 3'(i);
    end
  end

  // interrupt latch and entry; the choice stays fixed once made unless a trap at a boundary replaces it
  logic boundary;
  assign boundary = in_run & core.insn_done & core_rst_n_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_ff <= 1'b0;
      imask_q_ff <= 1'b1;
      take_ff <= 1'b0;
      pcm1_ff <= 1'b0;
      imask_set_ff <= 1'b0;
      vec_ff <= VEC_RESET;
    end else if (ce) begin
      imask_q_ff <= core.imask;
      take_ff <= 1'b0;
      imask_set_ff <= 1'b0;
      if (!in_run) begin
        latched_ff <= 1'b0;
        vec_ff <= VEC_RESET;
      end else if (boundary && core.trap_exec) begin
        // software trap is never masked and stacks the plain pc
        take_ff <= 1'b1;
        pcm1_ff <= 1'b0;
        imask_set_ff <= 1'b1;
        vec_ff <= VEC_TRAP;
      end else if (boundary && !latched_ff && !core.imask && |active) begin
        latched_ff <= 1'b1;
        take_ff <= 1'b1;
        pcm1_ff <= 1'b1;
        imask_set_ff <= 1'b1;
        vec_ff <= 16'(VEC_IRQ_BASE - {12'h000, pick, 1'b0});
      end else if (latched_ff &&
                   (core.vec_ack || (imask_q_ff && !core.imask))) begin
        latched_ff <= 1'b0;
      end
    end
  end

  // apb slave: one wait state, data captured in the setup cycle
  logic setup, access, mapped;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign mapped = (paddr == OFS_CAUSE) || (paddr == OFS_PEND) ||
                  (paddr == OFS_CTRL) || (paddr == OFS_IRQ_EN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= psel & penable & ~pready_ff;
      if (setup) begin
        pslverr_ff <= ~mapped;
        case (paddr)
          OFS_CAUSE: prdata_ff <= {26'h0, cause_ff};
          // low two bits are hard zero
          OFS_PEND: prdata_ff <= {24'h0, irq_req, 2'b00};
          OFS_CTRL: prdata_ff <= {30'h0, ctrl_ff};
          OFS_IRQ_EN: prdata_ff <= {26'h0, irq_en_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // writable registers; status and cause ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 2'b00;
      irq_en_ff <= '0;
    end else if (ce) begin
      if (access && pwrite && paddr == OFS_CTRL) ctrl_ff <= pwdata[1:0];
      if (state_ff == RS_DRIVE) irq_en_ff <= '0;
      else if (access && pwrite && paddr == OFS_IRQ_EN) begin
        irq_en_ff <= pwdata[NIRQ-1:0];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ext_reset_o = 1'b0; // open drain: only the enable moves
  assign ext_reset_oe = ext_oe_ff;
  assign core_reset_n = core_rst_n_ff;
  assign bus_clk_en = bus_en_ff;
  assign wdog_tick = wdog_ff;
  assign int_take = take_ff;
  assign vector_addr = vec_ff;
  assign stack_pc_minus1 = pcm1_ff;
  assign set_imask = imask_set_ff;
  assign push_index_high = 1'b0;

  property p_bad_op;
    @(posedge pclk) disable iff (!presetn)
    (ce && bad_op_evt && !droop_evt && !mon_evt && !bad_addr_evt)
      |=> (state_ff == RS_DRIVE) && cause_ff.bad_op && ext_reset_oe;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("opcode reset missed");

  property p_line_low;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == RS_DRIVE && $past(state_ff) == RS_DRIVE) |-> ext_reset_oe;
  endproperty
  a_line_low: assert property (p_line_low) else $error("line not low");

  property p_data_read;
    @(posedge pclk) disable iff (!presetn)
    (ce && in_run && core.fetch_unmapped && !core.opcode_fetch &&
     !droop_evt && !mon_evt && !bad_op_evt)
      |=> !cause_ff.bad_addr || $past(cause_ff.bad_addr);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read reset");

  property p_pre_step;
    @(posedge pclk) disable iff (!presetn)
    (ce && osc_tick && !pre_clr && state_ff != RS_STOP)
      |=> pre_ff == 12'($past(pre_ff) + 12'h001);
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("prescaler step");

  property p_wdog;
    @(posedge pclk) disable iff (!presetn)
    $rose(wdog_tick) |-> $past(pre_ff) == PRE_MAX;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog tick wrong");

  property p_bus_off;
    @(posedge pclk) disable iff (!presetn)
    // the enable flop tracks the state, so both agree in every cycle
    (state_ff == RS_STAB || state_ff == RS_RECOV) |-> !bus_clk_en;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus clock early");

  property p_stop_clr;
    @(posedge pclk) disable iff (!presetn)
    (ce && stop_ok && !int_src && !pin_low && !droop_evt)
      |=> (pre_ff == 12'h000) && (state_ff == RS_STOP) ##1 !bus_clk_en;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop no clear");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (latched_ff && ce && !core.vec_ack && core.imask && in_run)
      |=> latched_ff && $stable(vector_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("latch displaced");

  property p_pend_low;
    @(posedge pclk) disable iff (!presetn)
    (ce && setup && paddr == OFS_PEND) |=> prdata[1:0] == 2'b00 &&
      prdata[7:2] == $past(irq_req);
  endproperty
  a_pend_low: assert property (p_pend_low) else $error("status wrong");
endmodule
`default_nettype wire

// ### include/res_pkg.sv
package res_pkg;
  // register byte addresses
  localparam logic [15:0] OFS_CAUSE = 16'hfe00;
  localparam logic [15:0] OFS_PEND = 16'hfe04;
  localparam logic [15:0] OFS_CTRL = 16'hfe08;
  localparam logic [15:0] OFS_IRQ_EN = 16'hfe0c;
  // field positions
  localparam int CTRL_STOPEN_BIT = 0;
  localparam int CTRL_SHORT_BIT = 1;
  localparam int PEND_LSB = 2;
  // pin synchroniser lanes
  localparam int SY_OSC = 0;
  localparam int SY_DROOP = 1;
  localparam int SY_MON = 2;
  localparam int SY_PIN = 3;
  localparam int SY_N = 4;
  // timing in oscillator ticks
  localparam logic [11:0] PRE_MAX = 12'hfff;
  localparam logic [11:0] PRE_SHORT_LAST = 12'h01f;
  localparam logic [5:0] PHASE_LAST = 6'h1f;
  // vector addresses
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_IRQ_BASE = 16'hfffa;
  // reset cause fields, one-hot after each reset
  typedef struct packed {
    logic por;
    logic pin;
    logic mon_entry;
    logic droop;
    logic bad_addr;
    logic bad_op;
  } res_cause_t;
  // signals from the processor core, same clock
  typedef struct packed {
    logic insn_done;
    logic opcode_valid;
    logic opcode_illegal;
    logic stop_exec;
    logic trap_exec;
    logic fetch_unmapped;
    logic opcode_fetch;
    logic imask;
    logic vec_ack;
  } res_core_t;
  typedef enum logic [2:0] {
    RS_RUN = 3'b000,
    RS_STAB = 3'b001,
    RS_DRIVE = 3'b010,
    RS_HOLD = 3'b011,
    RS_STOP = 3'b100,
    RS_RECOV = 3'b101,
    RS_EXT = 3'b110
  } res_state_t;
endpackage

// ### bench/res_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor core stand-in: raises one-cycle events, keeps the mask bit,
// and acknowledges a taken vector a few cycles later like a real fetch
module res_core_model import res_pkg::*; #(
  parameter int ACK_DLY = 3
) (
  input wire logic pclk,
  input wire logic core_reset_n,
  input wire logic int_take,
  input wire logic set_imask,
  output res_core_t core
);
  res_core_t ev_ff = '0; // events shown for the current cycle
  logic ret_ff = 1'b0; // return from trap shown this cycle
  logic imask_ff = 1'b0; // core interrupt mask bit
  logic [7:0] ack_ff = 8'h00; // delay line from vector fetch to ack
  // mask and ack are merged over whatever event is on the lines;
  // a return clears the mask in the very cycle that it shows
  always_comb begin
    core = ev_ff;
    core.imask = imask_ff & ~ret_ff;
    core.vec_ack = ack_ff[ACK_DLY-1];
  end
  // mask set on entry; a core reset leaves it clear so tests start open
  always @(posedge pclk) begin
    ack_ff <= {ack_ff[6:0], int_take};
    if (!core_reset_n) begin
      imask_ff <= 1'b0;
    end else if (set_imask) begin
      imask_ff <= 1'b1;
    end else if (ret_ff) begin
      imask_ff <= 1'b0;
    end
  end
  // one-cycle event, optionally a return from trap as well
  task automatic issue(input res_core_t ev, input logic ret);
    @(posedge pclk);
    ev_ff <= ev;
    ret_ff <= ret;
    @(posedge pclk);
    ev_ff <= '0;
    ret_ff <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/reset_exception_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_exception_sequencer_tb import res_pkg::*; ;
  logic pclk = 1'b0; // 10 MHz bus clock
  logic presetn = 1'b0; // power-up pulse
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic osc = 1'b0, droop = 1'b0, mon = 1'b0, wake = 1'b0;
  logic pin = 1'b1; // external reset pin, idle high
  logic [5:0] irq_req = 6'h00; // bit0 is the highest priority source
  logic [2:0] osc_div = 3'h0;
  wire logic [31:0] prdata;
  wire logic [15:0] vector_addr;
  wire logic pready, pslverr, oe, core_reset_n, bus_clk_en;
  wire logic int_take, pcm1, set_imask, push_ih;
  wire logic wdog, line_o;
  wire res_core_t core;
  int num_errors = 0;
  int num_checks = 0;
  int wdog_cnt = 0; // watchdog ticks seen since power-up
  res_seq res_seq_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_pin(osc), .supply_droop_pin(droop),
    .monitor_entry_reset_pin(mon), .ext_reset_pin_i(pin),
    .ext_reset_o(line_o), .ext_reset_oe(oe), .core(core), .irq_req(irq_req),
    .wake_i(wake), .core_reset_n(core_reset_n), .bus_clk_en(bus_clk_en),
    .wdog_tick(wdog), .int_take(int_take), .vector_addr(vector_addr),
    .stack_pc_minus1(pcm1), .set_imask(set_imask),
    .push_index_high(push_ih));
  res_core_model res_core_model_inst (.pclk(pclk),
    .core_reset_n(core_reset_n), .int_take(int_take),
    .set_imask(set_imask), .core(core));
  always #50 pclk = ~pclk;
  // oscillator: 8 bus clocks a tick so the synchroniser sees every level
  always @(posedge pclk) begin
    osc_div <= (osc_div == 3'h3) ? 3'h0 : osc_div + 3'h1;
    if (osc_div == 3'h3) begin
      osc <= ~osc;
    end
  end
  // count watchdog ticks as the far side would
  always @(posedge pclk) begin
    if (wdog === 1'b1) begin
      wdog_cnt <= wdog_cnt + 1;
    end
  end
  task automatic tick();
    @(posedge pclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    num_errors++;
    $display("ERROR t=%0t wait ran out exp=%h got=%h", $time, 1, 0);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // tick counts allow one tick of slack: oscillator phase is free
  task automatic chk_near(input int exp, input int got);
    num_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) give_up();
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(exp, r);
  endtask
  // line held low, then core held in reset, then cause read back
  task automatic meas(input int oe_ticks, input logic [31:0] cause);
    int c;
    c = 0;
    while (oe !== 1'b1) begin
      tick();
      if (++c > 20) give_up();
    end
    chk(32'hfffe, 32'(vector_addr));
    c = 0;
    while (oe === 1'b1) begin
      tick();
      if (++c > 40000) give_up();
    end
    chk_near(oe_ticks, (c + 4) / 8);
    c = 0;
    while (core_reset_n !== 1'b1) begin
      tick();
      if (++c > 1000) give_up();
    end
    chk_near(32, (c + 4) / 8);
    rchk(OFS_CAUSE, cause);
  endtask
  // expect a take (or none) within a few cycles of the boundary
  task automatic take(input logic t, input logic [15:0] v, input logic p);
    logic seen;
    seen = 1'b0;
    // the take pulse may already stand from the boundary edge
    #1;
    for (int c = 0; c < 6 && !seen; c++) begin
      seen = (int_take === 1'b1);
      if (!seen) tick();
    end
    chk({31'h0, t}, {31'h0, seen});
    if (seen) begin
      chk({16'h0, v}, {16'h0, vector_addr});
      chk({31'h0, p}, {31'h0, pcm1});
      chk(32'h1, {31'h0, set_imask});
      chk(32'h0, {31'h0, push_ih});
      // a real core fetches the vector before its next boundary
      repeat (4) tick();
    end
  endtask
  task automatic t_por();
    tick();
    presetn <= 1'b1;
    tick();
    chk(32'h0, {31'h0, bus_clk_en});
    chk(32'h0, {31'h0, line_o});
    meas(4096 + 32, 32'h20);
    chk(32'h1, {31'h0, bus_clk_en});
    chk(32'h1, 32'(wdog_cnt));
    rchk(OFS_PEND, 32'h0);
    $display("power-up test done");
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    irq_req <= 6'h2d;
    rchk(OFS_PEND, 32'hb4);
    wr(OFS_PEND, 32'hffffffff);
    rchk(OFS_PEND, 32'hb4);
    apb(1'b0, 16'hfe10, 32'h0, r, e);
    chk(32'h0, r);
    chk(32'h1, {31'h0, e});
    irq_req <= 6'h00;
    $display("register test done");
  endtask
  task automatic t_irq();
    res_core_t ev;
    ev = '0;
    ev.insn_done = 1'b1;
    wr(OFS_IRQ_EN, 32'h3f);
    irq_req <= 6'h0a;
    res_core_model_inst.issue(ev, 1'b0);
    take(1'b1, 16'hfff8, 1'b1);
    irq_req <= 6'h09;
    tick();
    tick();
    chk(32'hfff8, {16'h0, vector_addr});
    res_core_model_inst.issue(ev, 1'b0);
    take(1'b0, 16'h0, 1'b0);
    res_core_model_inst.issue(ev, 1'b1);
    take(1'b1, 16'hfffa, 1'b1);
    irq_req <= 6'h00;
    ev.trap_exec = 1'b1;
    res_core_model_inst.issue(ev, 1'b0);
    take(1'b1, 16'hfffc, 1'b0);
    ev.trap_exec = 1'b0;
    wr(OFS_IRQ_EN, 32'h20);
    irq_req <= 6'h10;
    res_core_model_inst.issue(ev, 1'b1);
    take(1'b0, 16'h0, 1'b0);
    irq_req <= 6'h00;
    $display("interrupt test done");
  endtask
  task automatic t_stop();
    res_core_t ev;
    int c;
    ev = '0;
    ev.stop_exec = 1'b1;
    // a canned oscillator, so the short recovery is allowed here
    wr(OFS_CTRL, 32'h3);
    res_core_model_inst.issue(ev, 1'b0);
    for (c = 0; c < 10; c++) tick();
    chk(32'h0, {30'h0, oe, bus_clk_en});
    @(posedge pclk);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    c = 0;
    while (bus_clk_en !== 1'b1) begin
      tick();
      if (++c > 2000) give_up();
    end
    chk_near(32, (c + 4) / 8);
    $display("stop test done");
  endtask
  task automatic t_resets();
    res_core_t ev;
    int c;
    logic [5:0] cause [4] = '{6'h01, 6'h01, 6'h02, 6'h08};
    // stop must be disabled for the stop-as-bad-opcode case
    wr(OFS_CTRL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ev = '0;
      ev.opcode_valid = (k == 0);
      ev.opcode_illegal = (k == 0);
      ev.stop_exec = (k == 1);
      ev.fetch_unmapped = (k == 2);
      ev.opcode_fetch = (k == 2);
      if (k == 3) begin
        @(posedge pclk);
        mon <= 1'b1;
        repeat (4) @(posedge pclk);
        mon <= 1'b0;
      end else begin
        res_core_model_inst.issue(ev, 1'b0);
      end
      meas(32, {26'h0, cause[k]});
    end
    ev = '0;
    ev.fetch_unmapped = 1'b1;
    res_core_model_inst.issue(ev, 1'b0);
    for (c = 0; c < 30; c++) begin
      tick();
      chk(32'h0, {31'h0, oe});
    end
    rchk(OFS_CAUSE, 32'h08);
    $display("internal reset test done");
  endtask
  // pin reset: core held while low, line left alone, pin cause kept
  task automatic t_pin();
    int c;
    @(posedge pclk);
    pin <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'h0, {30'h0, oe, core_reset_n});
    pin <= 1'b1;
    c = 0;
    while (core_reset_n !== 1'b1) begin
      tick();
      if (++c > 20) give_up();
    end
    rchk(OFS_CAUSE, 32'h10);
    $display("pin reset test done");
  endtask
  task automatic t_droop();
    @(posedge pclk);
    droop <= 1'b1;
    repeat (4) @(posedge pclk);
    droop <= 1'b0;
    meas(4096 + 32, 32'h04);
    $display("supply droop test done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    t_por();
    t_regs();
    t_irq();
    t_stop();
    t_resets();
    t_pin();
    t_droop();
    print_verdict();
  end
endmodule
`default_nettype wire
